// File: rxifb_frame_builder.sv
// Design decisions made here: the placing of the registers and the APB register port.
`default_nettype none
module rxifb_frame_builder
   import rxifb_pkg::*;
#(
   parameter int FIFO_W = 8,
   parameter int FIFO_D = 2
)(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                clk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                upd_valid,
   output logic                     upd_ready,
   input  wire logic [63:0]         upd_new_addr,
   input  wire logic                rx_hdr_valid,
   output logic                     rx_hdr_ready,
   input  wire rxifb_rx_hdr_t       rx_hdr,
   input  wire logic                pay_valid,
   output logic                     pay_ready,
   input  wire logic [7:0]          pay_data,
   output logic                     tx_valid,
   input  wire logic                tx_ready,
   output logic [FIFO_W-1:0]        tx_data
);
   // -------------------------------------------------
   // Declarations
   // -------------------------------------------------
   rxifb_state_t        state_ff;        // Sequencer state
   rxifb_kind_t         kind_ff;         // Frame being built
   rxifb_rx_hdr_t       hdr_ff;          // Latched packet header
   logic [63:0]         new_ff;          // Applied destination
   logic [63:0]         old_ff;          // Previous destination
   logic [15:0]         idx_ff;          // Current byte offset
   logic [15:0]         hdr_last_ff;     // Last header offset
   logic [15:0]         len_ff;          // Length field
   logic [15:0]         cnt_ff;          // Payload bytes left
   logic [7:0]          type_ff;         // Frame type byte
   logic [7:0]          sum_ff;          // Running data sum
   logic                ao_ff;           // Receive output option
   logic [31:0]         dh_ff;           // Destination high
   logic [31:0]         dl_ff;           // Destination low
   logic [7:0]          dsep_ff;         // Default source endpoint
   logic [7:0]          ddep_ff;         // Default dest endpoint
   logic [15:0]         dclu_ff;         // Default cluster
   logic [15:0]         frames_ff;       // Frames emitted
   logic [7:0]          drops_ff;        // Packets discarded
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;
   logic [63:0]         a64;
   logic [15:0]         a_last;
   logic [5:0]          sh;
   logic [7:0]          opts_m;
   logic [7:0]          hdr_byte;
   logic [7:0]          gen_byte;
   logic                gen_valid;
   logic                gen_fire;
   logic                in_ready;
   logic                plain;
   logic                upd_take;
   logic                rx_take;
   logic                mapped;
   logic [FIFO_W-1:0]   mem_ff [FIFO_D];
   logic [$clog2(FIFO_D)-1:0] wp_ff;
   logic [$clog2(FIFO_D)-1:0] rp_ff;
   logic [$clog2(FIFO_D+1)-1:0] fcnt_ff;

   // -------------------------------------------------
   // Handshakes
   // -------------------------------------------------
   // Updates take priority over packets
   assign upd_ready    = clk_en && state_ff == ST_IDLE;
   assign rx_hdr_ready = upd_ready && !upd_valid;
   assign upd_take     = upd_ready && upd_valid;
   assign rx_take      = rx_hdr_ready && rx_hdr_valid;
   assign plain        = rx_hdr.tx_type == TYPE_TX_PLAIN;
   assign gen_valid    = state_ff == ST_HDR || state_ff == ST_SUM
                         || (state_ff == ST_PAY && pay_valid);
   assign gen_fire     = clk_en && gen_valid && in_ready;
   // Payload drains into the buffer or is discarded
   assign pay_ready    = clk_en && ((state_ff == ST_PAY && in_ready)
                         || state_ff == ST_DROP);

   // -------------------------------------------------
   // Header byte selection
   // -------------------------------------------------
   always_comb
   begin
      a64    = hdr_ff.src64;
      a_last = OFS_SRC64_LAST;
      // Update notice: new address, then old
      if (kind_ff == K_UPD && idx_ff <= OFS_NEW_LAST)
      begin
         a64    = new_ff;
         a_last = OFS_NEW_LAST;
      end
      else if (kind_ff == K_UPD)
      begin
         a64    = old_ff;
         a_last = OFS_OLD_LAST;
      end
      sh     = 6'((a_last - idx_ff) << 3);
      opts_m = hdr_ff.opts & OPT_KEEP_MASK;
      case (idx_ff)
         OFS_DELIM:  hdr_byte = START_DELIM;
         OFS_LEN_HI: hdr_byte = len_ff[15:8];
         OFS_LEN_LO: hdr_byte = len_ff[7:0];
         OFS_TYPE:   hdr_byte = type_ff;
         default:
         begin
            if (kind_ff == K_UPD && idx_ff == OFS_FMT)
               hdr_byte = FORMAT_ID;
            else if (kind_ff == K_UPD || idx_ff <= OFS_SRC64_LAST)
               hdr_byte = 8'(a64 >> sh);
            else if (idx_ff == OFS_SRC16_HI)
               hdr_byte = hdr_ff.src16[15:8];
            else if (idx_ff == OFS_SRC16_LO)
               hdr_byte = hdr_ff.src16[7:0];
            else if (kind_ff == K_STD)
               hdr_byte = opts_m;
            else
            begin
               // Explicit frame extra fields
               case (idx_ff)
                  OFS_SRC_EP: hdr_byte = hdr_ff.src_ep;
                  OFS_DST_EP: hdr_byte = hdr_ff.dst_ep;
                  OFS_CLU_HI: hdr_byte = hdr_ff.cluster[15:8];
                  OFS_CLU_LO: hdr_byte = hdr_ff.cluster[7:0];
                  OFS_PRO_HI: hdr_byte = hdr_ff.profile[15:8];
                  OFS_PRO_LO: hdr_byte = hdr_ff.profile[7:0];
                  default:    hdr_byte = opts_m;
               endcase
            end
         end
      endcase
   end

   // Byte offered to the buffer
   always_comb
   begin
      case (state_ff)
         ST_PAY:  gen_byte = pay_data;
         ST_SUM:  gen_byte = CKSUM_BASE - sum_ff;
         default: gen_byte = hdr_byte;
      endcase
   end

   // -------------------------------------------------
   // Frame sequencer
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff    <= ST_IDLE;
         kind_ff     <= K_UPD;
         hdr_ff      <= '0;
         new_ff      <= '0;
         old_ff      <= '0;
         idx_ff      <= '0;
         hdr_last_ff <= '0;
         len_ff      <= '0;
         cnt_ff      <= '0;
         type_ff     <= '0;
         frames_ff   <= '0;
         drops_ff    <= '0;
      end
      else if (clk_en)
      begin
         case (state_ff)
            ST_IDLE:
            begin
               idx_ff <= OFS_DELIM;
               // Address update applies and announces
               if (upd_take)
               begin
                  kind_ff     <= K_UPD;
                  new_ff      <= upd_new_addr;
                  old_ff      <= {dh_ff, dl_ff};
                  type_ff     <= TYPE_ADDR_UPD;
                  len_ff      <= UPD_LEN;
                  hdr_last_ff <= UPD_HDR_LAST;
                  cnt_ff      <= '0;
                  state_ff    <= ST_HDR;
               end
               // Invalid delivery mode: swallow payload
               else if (rx_take && rx_hdr.opts[7:6] == MODE_INVALID)
               begin
                  drops_ff <= drops_ff + 8'h01;
                  cnt_ff   <= rx_hdr.pay_len;
                  if (rx_hdr.pay_len != '0)
                     state_ff <= ST_DROP;
               end
               else if (rx_take)
               begin
                  hdr_ff <= rx_hdr;
                  if (plain)
                  begin
                     hdr_ff.src_ep  <= dsep_ff;
                     hdr_ff.dst_ep  <= ddep_ff;
                     hdr_ff.cluster <= dclu_ff;
                  end
                  cnt_ff   <= rx_hdr.pay_len;
                  state_ff <= ST_HDR;
                  if (ao_ff)
                  begin
                     kind_ff     <= K_EXP;
                     type_ff     <= TYPE_RX_EXPL;
                     len_ff      <= EXP_LEN_BASE + rx_hdr.pay_len;
                     hdr_last_ff <= EXP_HDR_LAST;
                  end
                  else
                  begin
                     kind_ff     <= K_STD;
                     type_ff     <= TYPE_RX_STD;
                     len_ff      <= STD_LEN_BASE + rx_hdr.pay_len;
                     hdr_last_ff <= STD_HDR_LAST;
                  end
               end
            end
            ST_HDR:
            begin
               if (gen_fire)
               begin
                  idx_ff <= idx_ff + 16'h0001;
                  if (idx_ff == hdr_last_ff)
                     state_ff <= (cnt_ff != '0) ? ST_PAY : ST_SUM;
               end
            end
            ST_PAY:
            begin
               if (gen_fire)
               begin
                  idx_ff <= idx_ff + 16'h0001;
                  cnt_ff <= cnt_ff - 16'h0001;
                  if (cnt_ff == 16'h0001)
                     state_ff <= ST_SUM;
               end
            end
            ST_SUM:
            begin
               if (gen_fire)
               begin
                  frames_ff <= frames_ff + 16'h0001;
                  state_ff  <= ST_IDLE;
               end
            end
            ST_DROP:
            begin
               if (pay_valid)
               begin
                  cnt_ff <= cnt_ff - 16'h0001;
                  if (cnt_ff == 16'h0001)
                     state_ff <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Checksum over bytes from the type onward
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sum_ff <= '0;
      else if (clk_en)
      begin
         if (state_ff == ST_IDLE)
            sum_ff <= '0;
         else if (gen_fire && state_ff != ST_SUM && idx_ff >= OFS_TYPE)
            sum_ff <= sum_ff + gen_byte;
      end
   end

   // -------------------------------------------------
   // Output buffer
   // -------------------------------------------------
   assign in_ready = fcnt_ff != FIFO_D[$clog2(FIFO_D+1)-1:0];
   // Gated so that no byte leaves while the state is frozen
   assign tx_valid = clk_en && fcnt_ff != '0;
   assign tx_data  = mem_ff[rp_ff];

   // Storage, one flop row per entry
   genvar e;
   generate
      for (e = 0; e < FIFO_D; e++)
      begin : g_ent
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               mem_ff[e] <= '0;
            else if (clk_en && gen_fire && wp_ff == e)
               mem_ff[e] <= FIFO_W'(gen_byte);
         end
      end
   endgenerate

   // Pointers and fill level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_ff   <= '0;
         rp_ff   <= '0;
         fcnt_ff <= '0;
      end
      else if (clk_en)
      begin
         if (gen_fire)
            wp_ff <= (wp_ff == FIFO_D - 1) ? '0 : wp_ff + 1'b1;
         if (tx_valid && tx_ready)
            rp_ff <= (rp_ff == FIFO_D - 1) ? '0 : rp_ff + 1'b1;
         fcnt_ff <= fcnt_ff + gen_fire - (tx_valid && tx_ready);
      end
   end

   // -------------------------------------------------
   // APB registers
   // -------------------------------------------------
   assign pready  = clk_en;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;
   assign mapped  = paddr <= REG_STATUS && paddr[1:0] == 2'h0;

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end
      else if (clk_en && psel && !penable)
      begin
         pslverr_ff <= !mapped;
         case (paddr)
            REG_CTRL:    prdata_ff <= {31'h0, ao_ff};
            REG_DEST_HI: prdata_ff <= dh_ff;
            REG_DEST_LO: prdata_ff <= dl_ff;
            REG_DEF_EP:  prdata_ff <= {16'h0, ddep_ff, dsep_ff};
            REG_DEF_CLU: prdata_ff <= {16'h0, dclu_ff};
            REG_STATUS:  prdata_ff <= {frames_ff, drops_ff, 7'h0,
                                       state_ff != ST_IDLE || tx_valid};
            default:     prdata_ff <= '0;
         endcase
      end
   end

   // Writes land at the access edge; update wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ao_ff   <= 1'b0;
         dh_ff   <= DEST_RST;
         dl_ff   <= DEST_RST;
         dsep_ff <= DEF_EP_RST;
         ddep_ff <= DEF_EP_RST;
         dclu_ff <= DEF_CLU_RST;
      end
      else if (clk_en)
      begin
         if (psel && penable && pwrite)
         begin
            case (paddr)
               REG_CTRL:    ao_ff <= pwdata[0];
               REG_DEST_HI: dh_ff <= pwdata;
               REG_DEST_LO: dl_ff <= pwdata;
               REG_DEF_EP:  {ddep_ff, dsep_ff} <= pwdata[15:0];
               REG_DEF_CLU: dclu_ff <= pwdata[15:0];
               default:     ao_ff <= ao_ff;
            endcase
         end
         if (upd_take)
            {dh_ff, dl_ff} <= upd_new_addr;
      end
   end

   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_upd_take;
      upd_valid && upd_ready;
   endsequence
   sequence s_fire_at(logic [15:0] ofs);
      gen_fire && state_ff == ST_HDR && idx_ff == ofs;
   endsequence

   a_upd_type_byte: assert property (s_fire_at(OFS_TYPE) ##0 kind_ff == K_UPD
      |-> gen_byte == TYPE_ADDR_UPD) else $error("update type wrong");
   a_upd_format_id: assert property (s_fire_at(OFS_FMT) ##0 kind_ff == K_UPD
      |-> gen_byte == FORMAT_ID) else $error("format id not zero");
   a_upd_dest_store: assert property (s_upd_take
      |=> {dh_ff, dl_ff} == $past(upd_new_addr) && old_ff == $past({dh_ff, dl_ff}))
      else $error("destination not applied");
   a_std_frame_type: assert property (rx_take && !ao_ff && rx_hdr.opts[7:6] != 2'h0
      |=> type_ff == 8'h90 && len_ff == 16'h000C + $past(rx_hdr.pay_len))
      else $error("standard frame type wrong");
   a_src_addr_msb: assert property (s_fire_at(16'h0004) ##0 kind_ff != K_UPD
      |-> gen_byte == hdr_ff.src64[63:56]) else $error("source msb wrong");
   a_payload_pass: assert property (gen_fire && state_ff == ST_PAY
      |-> pay_ready && gen_byte == pay_data && idx_ff > hdr_last_ff)
      else $error("payload byte wrong");
   a_opts_mode_valid: assert property (gen_fire && kind_ff == K_STD
      && idx_ff == OFS_STD_OPTS |-> gen_byte[7:6] != 2'h0 && gen_byte[5:2] == 4'h0)
      else $error("bad options byte");
   a_expl_frame_type: assert property (rx_take && ao_ff && rx_hdr.opts[7:6] != 2'h0
      |=> type_ff == 8'h91 && kind_ff == K_EXP) else $error("explicit type wrong");
   a_expl_profile: assert property (s_fire_at(16'h0012) ##0 kind_ff == K_EXP
      |-> gen_byte == hdr_ff.profile[15:8] ##1 hdr_ff.profile == $past(hdr_ff.profile))
      else $error("profile misplaced");
   a_expl_opts_pos: assert property (s_fire_at(16'h0014) ##0 kind_ff == K_EXP
      |-> gen_byte == (hdr_ff.opts & 8'hC3)) else $error("explicit options wrong");
   a_plain_defaults: assert property (rx_take && plain && rx_hdr.opts[7:6] != 2'h0
      |=> hdr_ff.src_ep == $past(dsep_ff) && hdr_ff.cluster == $past(dclu_ff))
      else $error("defaults not used");
   a_frame_delim: assert property (s_fire_at(16'h0000)
      |-> gen_byte == 8'h7E ##1 (idx_ff == 16'h0001 || !gen_fire))
      else $error("start delimiter wrong");
   a_cksum_close: assert property (gen_fire && state_ff == ST_SUM
      |-> (8'(gen_byte + sum_ff) == 8'hFF) ##1 state_ff == ST_IDLE)
      else $error("checksum wrong");

endmodule // rxifb_frame_builder
`default_nettype wire

// File: rxifb_pkg.sv
`default_nettype none
package rxifb_pkg;
   // -------------------------------------------------
   // Frame bytes
   // -------------------------------------------------
   localparam logic [7:0] START_DELIM   = 8'h7E;
   localparam logic [7:0] TYPE_ADDR_UPD = 8'h8E;
   localparam logic [7:0] TYPE_RX_STD   = 8'h90;
   localparam logic [7:0] TYPE_RX_EXPL  = 8'h91;
   localparam logic [7:0] TYPE_TX_PLAIN = 8'h10;
   localparam logic [7:0] FORMAT_ID     = 8'h00;
   localparam logic [7:0] CKSUM_BASE    = 8'hFF;
   localparam logic [7:0] OPT_KEEP_MASK = 8'hC3;   // Ack, bcast, mode
   localparam logic [1:0] MODE_INVALID  = 2'h0;
   // -------------------------------------------------
   // Byte offsets within a frame
   // -------------------------------------------------
   localparam logic [15:0] OFS_DELIM      = 16'h0000;
   localparam logic [15:0] OFS_LEN_HI     = 16'h0001;
   localparam logic [15:0] OFS_LEN_LO     = 16'h0002;
   localparam logic [15:0] OFS_TYPE       = 16'h0003;
   localparam logic [15:0] OFS_FMT        = 16'h0004;
   localparam logic [15:0] OFS_NEW_LAST   = 16'h000C;
   localparam logic [15:0] OFS_OLD_LAST   = 16'h0014;
   localparam logic [15:0] OFS_SRC64_LAST = 16'h000B;
   localparam logic [15:0] OFS_SRC16_HI   = 16'h000C;
   localparam logic [15:0] OFS_SRC16_LO   = 16'h000D;
   localparam logic [15:0] OFS_STD_OPTS   = 16'h000E;
   localparam logic [15:0] OFS_SRC_EP     = 16'h000E;
   localparam logic [15:0] OFS_DST_EP     = 16'h000F;
   localparam logic [15:0] OFS_CLU_HI     = 16'h0010;
   localparam logic [15:0] OFS_CLU_LO     = 16'h0011;
   localparam logic [15:0] OFS_PRO_HI     = 16'h0012;
   localparam logic [15:0] OFS_PRO_LO     = 16'h0013;
   localparam logic [15:0] OFS_EXP_OPTS   = 16'h0014;
   localparam logic [15:0] STD_HDR_LAST   = 16'h000E;
   localparam logic [15:0] EXP_HDR_LAST   = 16'h0014;
   localparam logic [15:0] UPD_HDR_LAST   = 16'h0014;
   localparam logic [15:0] STD_LEN_BASE   = 16'h000C;
   localparam logic [15:0] EXP_LEN_BASE   = 16'h0012;
   localparam logic [15:0] UPD_LEN        = 16'h0012;
   // -------------------------------------------------
   // Register map
   // -------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  REG_CTRL     = 8'h00;   // Bit 0 output option
   localparam logic [7:0]  REG_DEST_HI  = 8'h04;
   localparam logic [7:0]  REG_DEST_LO  = 8'h08;
   localparam logic [7:0]  REG_DEF_EP   = 8'h0C;   // [7:0] src, [15:8] dst
   localparam logic [7:0]  REG_DEF_CLU  = 8'h10;   // [15:0] cluster
   localparam logic [7:0]  REG_STATUS   = 8'h14;   // Busy, drops, frames
   localparam logic [31:0] DEST_RST     = 32'h00000000;
   localparam logic [7:0]  DEF_EP_RST   = 8'hE8;
   localparam logic [15:0] DEF_CLU_RST  = 16'h0011;
   // -------------------------------------------------
   // Types
   // -------------------------------------------------
   typedef struct packed {
      logic [63:0] src64;
      logic [15:0] src16;
      logic [7:0]  opts;
      logic [7:0]  tx_type;   // Request type the sender used
      logic [7:0]  src_ep;
      logic [7:0]  dst_ep;
      logic [15:0] cluster;
      logic [15:0] profile;
      logic [15:0] pay_len;
   } rxifb_rx_hdr_t;
   typedef enum logic [1:0] {K_UPD, K_STD, K_EXP} rxifb_kind_t;
   typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_PAY, ST_SUM, ST_DROP} rxifb_state_t;
endpackage
`default_nettype wire

// File: rxifb_host_model.sv
`default_nettype none
// ---------------------------------------
// Host side of the frame byte stream
// ---------------------------------------
module rxifb_host_model
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            got,
   output logic [7:0]      got_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pace_ff;   // Stall pattern counter
   // Takes bytes, stalling three cycles in sixteen so the buffer fills
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pace_ff  <= 4'h0;
         tx_ready <= 1'b0;
         got      <= 1'b0;
         got_byte <= 8'h00;
      end
      else
      begin
         pace_ff  <= pace_ff + 4'h1;
         tx_ready <= (pace_ff < 4'hD);
         got      <= tx_valid && tx_ready;
         got_byte <= tx_data;   // Option bits outside OPT_KEEP_MASK arrive already cleared
      end
   end
endmodule // rxifb_host_model
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb import rxifb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, pe, drop;
   logic upd_valid, upd_ready, rx_hdr_valid, rx_hdr_ready, pay_valid, pay_ready;
   logic tx_valid, tx_ready, got, jit;   // jit lets clk_en drop at random
   logic [7:0]    paddr, pay_data, tx_data, got_byte, sum;
   logic [31:0]   pwdata, prdata, rd;
   logic [63:0]   upd_new_addr, dest;
   rxifb_rx_hdr_t rx_hdr;
   logic [7:0]    q[$];   // Expected stream bytes
   int            num_errors, compares, cyc;
   rxifb_frame_builder uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .upd_valid(upd_valid), .upd_ready(upd_ready),
      .upd_new_addr(upd_new_addr), .rx_hdr_valid(rx_hdr_valid), .rx_hdr_ready(rx_hdr_ready),
      .rx_hdr(rx_hdr), .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
   rxifb_host_model host (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .got(got), .got_byte(got_byte));
   // -------------------
   // Helpers
   // -------------------
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] seen);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      if (num_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Notes one expected byte, summed for the checksum
   task automatic pb(logic [7:0] b);
      if (!drop)
         q.push_back(b);
      sum = sum + b;
   endtask
   task automatic hdr(logic [15:0] len, logic [7:0] ty);
      pb(START_DELIM);
      pb(len[15:8]);
      pb(len[7:0]);
      sum = 8'h00;
      pb(ty);
   endtask
   // One APB transfer, held until pready is seen
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Address update and its notice frame
   task automatic upd(logic [63:0] a);
      drop = 1'b0;
      hdr(UPD_LEN, TYPE_ADDR_UPD);
      pb(FORMAT_ID);
      for (int i = 7; i >= 0; i--) pb(a[i*8 +: 8]);
      for (int i = 7; i >= 0; i--) pb(dest[i*8 +: 8]);
      pb(8'hFF - sum);
      dest = a;
      upd_new_addr <= a;
      upd_valid <= 1'b1;
      do @(posedge pclk); while (upd_ready !== 1'b1);
      upd_valid <= 1'b0;
      @(posedge pclk);
   endtask
   // Received packet: header, n payload bytes, expected frame
   task automatic rx(logic ex, logic [1:0] md, int n, logic [7:0] ty);
      rxifb_rx_hdr_t h;
      logic [7:0] p[16];
      h = {$urandom, $urandom, $urandom, $urandom, $urandom};
      h.opts[7:6] = md;
      h.tx_type = ty;
      h.pay_len = 16'(n);
      drop = (md == MODE_INVALID);
      hdr(16'(n) + (ex ? EXP_LEN_BASE : STD_LEN_BASE), ex ? TYPE_RX_EXPL : TYPE_RX_STD);
      for (int i = 7; i >= 0; i--) pb(h.src64[i*8 +: 8]);
      pb(h.src16[15:8]);
      pb(h.src16[7:0]);
      if (ex && ty == TYPE_TX_PLAIN)
      begin
         pb(8'hB6);
         pb(8'hA5);
         pb(8'h12);
         pb(8'h34);
      end
      else if (ex)
      begin
         pb(h.src_ep);
         pb(h.dst_ep);
         pb(h.cluster[15:8]);
         pb(h.cluster[7:0]);
      end
      if (ex)
      begin
         pb(h.profile[15:8]);
         pb(h.profile[7:0]);
      end
      pb(h.opts & OPT_KEEP_MASK);
      for (int i = 0; i < n; i++)
      begin
         p[i] = 8'($urandom);
         pb(p[i]);
      end
      pb(8'hFF - sum);
      rx_hdr <= h;
      rx_hdr_valid <= 1'b1;
      do @(posedge pclk); while (rx_hdr_ready !== 1'b1);
      rx_hdr_valid <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         pay_data <= p[i];
         pay_valid <= 1'b1;
         do @(posedge pclk); while (pay_ready !== 1'b1);
      end
      pay_valid <= 1'b0;
      @(posedge pclk);
   endtask
   // -------------------
   // Clock, watcher, sequence
   // -------------------
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Clock enable, low about one cycle in four while jit is set
   always @(posedge pclk)
      clk_en <= !jit || ($urandom % 4 != 0);
   // Compares each taken byte with the oldest note; cuts a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         num_errors++;
         final_report;
      end
      else if (got && q.size() == 0)
         chk("tx_extra", 32'h0, 32'h1);
      else if (got)
         chk("tx_byte", 32'(q.pop_front()), 32'(got_byte));
   end
   initial
   begin
      void'($urandom(90));
      {presetn, psel, penable, pwrite, upd_valid, rx_hdr_valid, pay_valid, jit} = '0;
      {paddr, pwdata, pay_data, upd_new_addr, rx_hdr, sum, dest} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_DEST_HI, 32'h0);
      chk("dest_hi_rst", DEST_RST, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'h1, 32'(pe));
      apb(1'b1, REG_CTRL, 32'h0);
      upd({$urandom, $urandom});
      upd({$urandom, $urandom});
      apb(1'b0, REG_DEST_LO, 32'h0);
      chk("dest_lo", dest[31:0], rd);
      for (int m = 0; m < 4; m++) rx(1'b0, 2'(m), m + 1, 8'h00);
      rx(1'b0, 2'h3, 0, 8'h00);
      apb(1'b1, REG_DEF_EP, 32'h0000A5B6);
      apb(1'b1, REG_DEF_CLU, 32'h00001234);
      apb(1'b1, REG_CTRL, 32'h1);
      jit = 1'b1;
      rx(1'b1, 2'h2, 3, TYPE_TX_PLAIN);
      rx(1'b1, 2'h1, 4, 8'h11);
      jit = 1'b0;
      while (q.size() != 0) @(posedge pclk);
      repeat (4) @(posedge pclk);
      // Eight frames sent, one packet dropped, idle
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", 32'h00080100, rd);
      final_report;
   end
endmodule // tb
`default_nettype wire
